// file: hdl/wcu_pkg.sv
// Constants and types shared by the watch comparator unit files.
package wcu_pkg;
  // ---------------------------------------------------------------------------
  // Scan path layout
  // ---------------------------------------------------------------------------
  localparam int SCAN_LEN      = 38;
  localparam int DATA_W        = 32;
  localparam int ADDR_FIELD_W  = 5;
  localparam int ADDR_LSB      = 32;
  localparam int RW_BIT        = 37;
  // ---------------------------------------------------------------------------
  // Register numbers inside the 5-bit address field
  // ---------------------------------------------------------------------------
  localparam logic [4:0] REG_U0_BASE   = 5'h08;
  localparam logic [4:0] REG_U1_BASE   = 5'h10;
  localparam logic [2:0] SUB_ADDR_VAL  = 3'h0;
  localparam logic [2:0] SUB_ADDR_MSK  = 3'h1;
  localparam logic [2:0] SUB_DATA_VAL  = 3'h2;
  localparam logic [2:0] SUB_DATA_MSK  = 3'h3;
  localparam logic [2:0] SUB_CTRL_VAL  = 3'h4;
  localparam logic [2:0] SUB_CTRL_MSK  = 3'h5;
  // ---------------------------------------------------------------------------
  // Control field positions
  // ---------------------------------------------------------------------------
  localparam int CTL_WRITE  = 0;
  localparam int CTL_SIZE   = 1;
  localparam int CTL_FETCH  = 3;
  localparam int CTL_USER   = 4;
  localparam int CTL_EXT    = 5;
  localparam int CTL_CHAIN  = 6;
  localparam int CTL_RANGE  = 7;
  localparam int CTL_ENABLE = 8;
  localparam int CTL_VAL_W  = 9;
  localparam int CTL_MSK_W  = 8;
  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [8:0]  RST_CTRLV = 9'h000;
  localparam logic [7:0]  RST_CTRLM = 8'hFF;
  // ---------------------------------------------------------------------------
  // TAP states
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    WCU_TLR = 4'h0, WCU_RTI = 4'h1, WCU_SDR = 4'h3, WCU_CDR = 4'h2,
    WCU_SHDR = 4'h6, WCU_E1DR = 4'h7, WCU_PDR = 4'h5, WCU_E2DR = 4'h4,
    WCU_UDR = 4'hC, WCU_SIR = 4'hD, WCU_CIR = 4'hF, WCU_SHIR = 4'hE,
    WCU_E1IR = 4'hA, WCU_PIR = 4'hB, WCU_E2IR = 4'h9, WCU_UIR = 4'h8
  } wcu_tap_t;
endpackage : wcu_pkg

// file: hdl/wcu_unit.sv
// One comparator unit: masked compare, chain register and break output.
`timescale 1ns/100ps
module wcu_unit (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        tap_rst_n,
  input  wire logic [31:0] addr_val,
  input  wire logic [31:0] addr_msk,
  input  wire logic [31:0] data_val,
  input  wire logic [31:0] data_msk,
  input  wire logic [8:0]  ctrl_val,
  input  wire logic [7:0]  ctrl_msk,
  input  wire logic        ctrl_wr,
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] bus_data,
  input  wire logic        bus_valid,
  input  wire logic [7:0]  bus_ctrl,
  input  wire logic        chain_in,
  input  wire logic        range_in,
  output logic             chain_out,
  output logic             range_out,
  output logic             hit
);
  // Mask set means the bit always matches.
  function automatic logic wcu_cmp(input logic [31:0] v, input logic [31:0] m,
                                   input logic [31:0] x);
    wcu_cmp = &(~(v ^ x) | m);
  endfunction : wcu_cmp

  logic [7:0] ctrl_seen;
  logic       ac_match;
  logic       d_match;

  always_comb begin
    ctrl_seen = bus_ctrl;
    ctrl_seen[wcu_pkg::CTL_CHAIN] = chain_in;
    ctrl_seen[wcu_pkg::CTL_RANGE] = range_in;
  end

  assign ac_match = bus_valid &&
    wcu_cmp(addr_val, addr_msk, bus_addr) &&
    wcu_cmp({24'h000000, ctrl_val[7:0]}, {24'hFFFFFF, ctrl_msk},
            {24'h000000, ctrl_seen});
  assign d_match   = wcu_cmp(data_val, data_msk, bus_data);
  assign range_out = ac_match && d_match;
  assign hit = ac_match && d_match && ctrl_val[wcu_pkg::CTL_ENABLE];

  // The chain register follows the data compare only on address and control hits.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chain_out <= 1'b0;
    end else if (!tap_rst_n || ctrl_wr) begin
      chain_out <= 1'b0;
    end else if (ac_match) begin
      chain_out <= d_match;
    end
  end

  chain_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_wr |=> !chain_out) else $error("chain not cleared");
endmodule : wcu_unit

// file: hdl/wcu_top.sv
// Two-unit watch comparator with its scan-path register access.
// Function
// - Two comparator units, each with address, data, control value/mask.
// - Register access through a 38-bit data, address, read/write path.
// - Write: data and register number shifted in with read/write bit set.
// - Read: register number shifted in, read/write zero, data ignored.
// - Access happens only on entering UPDATE-DR, never while shifting.
// - Mask one forces match; mask zero requires input equal value.
// - Control layout: write, size, type, user, ext, chain, range, enable.
// - Enable at bit 8, unmaskable, gates the break request.
// - Write bit compared with core write signal.
// - Size field compared with core transfer size.
// - Type bit compared with fetch or data cycle type.
// - User bit compared with not-translate signal.
// - Two-bit external condition input, one bit per unit.
// - Unit 1 chain output feeds unit 0 chain input.
// - Chain output registered, loaded with data match on address and control match.
// - Chain register cleared on control value write and debug tap reset.
// - Unit 1 range output feeds unit 0 range input.
// - Control bits 7 to 0 each have a mask bit.
// - Prefetch abort wins over breakpoint on the same fetch.
// - Debug entry disables interrupts; pending interrupt is remembered.
// - Data abort on watched access: watch wins, abort remembered.
`timescale 1ns/100ps
module wcu_top (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        TCK,
  input  wire logic        TMS,
  input  wire logic        TDI,
  input  wire logic        DEBUG_TAP_RESET_N,
  input  wire logic        SCAN_SELECT,
  output logic             TDO,
  input  wire logic [31:0] BUS_ADDR,
  input  wire logic [31:0] BUS_DATA,
  input  wire logic        BUS_VALID,
  input  wire logic        BUS_WRITE,
  input  wire logic [1:0]  BUS_SIZE,
  input  wire logic        FETCH_OR_DATA_BIT,
  input  wire logic        USER_OR_PRIVILEGED_BIT,
  input  wire logic [1:0]  EXTERNAL_CONDITION_INPUT,
  input  wire logic        PREFETCH_ABORT,
  input  wire logic        DATA_ABORT,
  input  wire logic        IRQ_PENDING,
  output logic             DEBUG_BREAK_REQUEST,
  output logic             LINK_OUTPUT,
  output logic             RANGE_OUTPUT,
  output logic             INTERRUPTS_DISABLED,
  output logic             IRQ_REMEMBERED,
  output logic             ABORT_REMEMBERED
);
  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  // Test pins come from the debugger's clock; two stages before any use.
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic       tck_d;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      tck_d <= 1'b0;
    end else begin
      sync1 <= {DEBUG_TAP_RESET_N, SCAN_SELECT, TDI, TMS, TCK};
      sync2 <= sync1;
      tck_d <= sync2[0];
    end
  end
  logic tck_rise;
  logic tck_fall;
  logic tms_s;
  logic tdi_s;
  logic sel_s;
  logic trst_n_s;
  assign tck_rise = sync2[0] && !tck_d;
  assign tck_fall = !sync2[0] && tck_d;
  assign tms_s    = sync2[1];
  assign tdi_s    = sync2[2];
  assign sel_s    = sync2[3];
  assign trst_n_s = sync2[4];

  // ---------------------------------------------------------------------------
  // TAP state machine
  // ---------------------------------------------------------------------------
  wcu_pkg::wcu_tap_t tap;
  wcu_pkg::wcu_tap_t next_tap;
  always_comb begin
    case (tap)
      wcu_pkg::WCU_TLR:  next_tap = tms_s ? wcu_pkg::WCU_TLR : wcu_pkg::WCU_RTI;
      wcu_pkg::WCU_RTI:  next_tap = tms_s ? wcu_pkg::WCU_SDR : wcu_pkg::WCU_RTI;
      wcu_pkg::WCU_SDR:  next_tap = tms_s ? wcu_pkg::WCU_SIR : wcu_pkg::WCU_CDR;
      wcu_pkg::WCU_CDR:  next_tap = tms_s ? wcu_pkg::WCU_E1DR
                                          : wcu_pkg::WCU_SHDR;
      wcu_pkg::WCU_SHDR: next_tap = tms_s ? wcu_pkg::WCU_E1DR
                                          : wcu_pkg::WCU_SHDR;
      wcu_pkg::WCU_E1DR: next_tap = tms_s ? wcu_pkg::WCU_UDR : wcu_pkg::WCU_PDR;
      wcu_pkg::WCU_PDR:  next_tap = tms_s ? wcu_pkg::WCU_E2DR
                                          : wcu_pkg::WCU_PDR;
      wcu_pkg::WCU_E2DR: next_tap = tms_s ? wcu_pkg::WCU_UDR
                                          : wcu_pkg::WCU_SHDR;
      wcu_pkg::WCU_UDR:  next_tap = tms_s ? wcu_pkg::WCU_SDR : wcu_pkg::WCU_RTI;
      wcu_pkg::WCU_SIR:  next_tap = tms_s ? wcu_pkg::WCU_TLR : wcu_pkg::WCU_CIR;
      wcu_pkg::WCU_CIR:  next_tap = tms_s ? wcu_pkg::WCU_E1IR
                                          : wcu_pkg::WCU_SHIR;
      wcu_pkg::WCU_SHIR: next_tap = tms_s ? wcu_pkg::WCU_E1IR
                                          : wcu_pkg::WCU_SHIR;
      wcu_pkg::WCU_E1IR: next_tap = tms_s ? wcu_pkg::WCU_UIR : wcu_pkg::WCU_PIR;
      wcu_pkg::WCU_PIR:  next_tap = tms_s ? wcu_pkg::WCU_E2IR
                                          : wcu_pkg::WCU_PIR;
      wcu_pkg::WCU_E2IR: next_tap = tms_s ? wcu_pkg::WCU_UIR
                                          : wcu_pkg::WCU_SHIR;
      wcu_pkg::WCU_UIR:  next_tap = tms_s ? wcu_pkg::WCU_SDR : wcu_pkg::WCU_RTI;
      default:           next_tap = wcu_pkg::WCU_TLR;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tap <= wcu_pkg::WCU_TLR;
    end else if (!trst_n_s) begin
      tap <= wcu_pkg::WCU_TLR;
    end else if (tck_rise) begin
      tap <= next_tap;
    end
  end

  // ---------------------------------------------------------------------------
  // Scan path and register file
  // ---------------------------------------------------------------------------
  logic [37:0] shreg;
  logic        upd_pulse;
  // Update fires once, on the edge that enters UPDATE-DR.
  assign upd_pulse = tck_rise && sel_s && trst_n_s &&
                     (next_tap == wcu_pkg::WCU_UDR) &&
                     (tap != wcu_pkg::WCU_UDR);

  logic [4:0]  sc_reg;
  logic        sc_wr;
  logic [31:0] sc_dat;
  assign sc_reg = shreg[wcu_pkg::ADDR_LSB +: wcu_pkg::ADDR_FIELD_W];
  assign sc_wr  = shreg[wcu_pkg::RW_BIT];
  assign sc_dat = shreg[wcu_pkg::DATA_W-1:0];

  logic [31:0] av   [2];
  logic [31:0] am   [2];
  logic [31:0] dv   [2];
  logic [31:0] dm   [2];
  logic [8:0]  cv   [2];
  logic [7:0]  cm   [2];
  logic [1:0]  cwr;
  logic [31:0] rd_word;

  function automatic logic [31:0] wcu_pick(input logic [2:0] sub,
      input logic [31:0] a, input logic [31:0] b, input logic [31:0] c,
      input logic [31:0] d, input logic [8:0] e, input logic [7:0] f);
    case (sub)
      wcu_pkg::SUB_ADDR_VAL: wcu_pick = a;
      wcu_pkg::SUB_ADDR_MSK: wcu_pick = b;
      wcu_pkg::SUB_DATA_VAL: wcu_pick = c;
      wcu_pkg::SUB_DATA_MSK: wcu_pick = d;
      wcu_pkg::SUB_CTRL_VAL: wcu_pick = {23'h000000, e};
      wcu_pkg::SUB_CTRL_MSK: wcu_pick = {24'h000000, f};
      default:               wcu_pick = 32'h0000_0000;
    endcase
  endfunction : wcu_pick

  always_comb begin
    if (sc_reg[4:3] == wcu_pkg::REG_U0_BASE[4:3]) begin
      rd_word = wcu_pick(sc_reg[2:0], av[0], am[0], dv[0], dm[0], cv[0],
                         cm[0]);
    end else if (sc_reg[4:3] == wcu_pkg::REG_U1_BASE[4:3]) begin
      rd_word = wcu_pick(sc_reg[2:0], av[1], am[1], dv[1], dm[1], cv[1],
                         cm[1]);
    end else begin
      rd_word = 32'h0000_0000;
    end
  end

  // Capture loads the word addressed by the last read update, keeping the field.
  logic [31:0] rd_hold;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      shreg <= 38'h00_0000_0000;
    end else if (tck_rise && sel_s && tap == wcu_pkg::WCU_CDR) begin
      shreg <= {shreg[37:32], rd_hold};
    end else if (tck_rise && sel_s && tap == wcu_pkg::WCU_SHDR) begin
      shreg <= {tdi_s, shreg[37:1]};
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rd_hold <= wcu_pkg::RST_WORD;
    end else if (upd_pulse && !sc_wr) begin
      rd_hold <= rd_word;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      TDO <= 1'b0;
    end else if (tck_fall) begin
      TDO <= shreg[0];
    end
  end

  for (genvar u = 0; u < 2; u++) begin : g_regs
    logic hit_u;
    assign hit_u = upd_pulse && sc_wr &&
                   (sc_reg[4:3] == (u == 0 ? wcu_pkg::REG_U0_BASE[4:3]
                                           : wcu_pkg::REG_U1_BASE[4:3]));
    assign cwr[u] = hit_u && sc_reg[2:0] == wcu_pkg::SUB_CTRL_VAL;
    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        av[u] <= wcu_pkg::RST_WORD;
        am[u] <= wcu_pkg::RST_WORD;
        dv[u] <= wcu_pkg::RST_WORD;
        dm[u] <= wcu_pkg::RST_WORD;
        cv[u] <= wcu_pkg::RST_CTRLV;
        cm[u] <= wcu_pkg::RST_CTRLM;
      end else if (hit_u) begin
        case (sc_reg[2:0])
          wcu_pkg::SUB_ADDR_VAL: av[u] <= sc_dat;
          wcu_pkg::SUB_ADDR_MSK: am[u] <= sc_dat;
          wcu_pkg::SUB_DATA_VAL: dv[u] <= sc_dat;
          wcu_pkg::SUB_DATA_MSK: dm[u] <= sc_dat;
          wcu_pkg::SUB_CTRL_VAL: cv[u] <= sc_dat[8:0];
          wcu_pkg::SUB_CTRL_MSK: cm[u] <= sc_dat[7:0];
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Comparator units
  // ---------------------------------------------------------------------------
  logic [7:0] ctl_in [2];
  logic [1:0] hit;
  logic       chain1;
  logic       range1;
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      ctl_in[u] = 8'h00;
      ctl_in[u][wcu_pkg::CTL_WRITE] = BUS_WRITE;
      ctl_in[u][wcu_pkg::CTL_SIZE +: 2] = BUS_SIZE;
      ctl_in[u][wcu_pkg::CTL_FETCH] = FETCH_OR_DATA_BIT;
      ctl_in[u][wcu_pkg::CTL_USER] = USER_OR_PRIVILEGED_BIT;
      ctl_in[u][wcu_pkg::CTL_EXT] = EXTERNAL_CONDITION_INPUT[u];
    end
  end

  wcu_unit u_unit1 (
    .clk       (CLK),          .nrst      (NRST),
    .tap_rst_n (trst_n_s),     .addr_val  (av[1]),
    .addr_msk  (am[1]),        .data_val  (dv[1]),
    .data_msk  (dm[1]),        .ctrl_val  (cv[1]),
    .ctrl_msk  (cm[1]),        .ctrl_wr   (cwr[1]),
    .bus_addr  (BUS_ADDR),     .bus_data  (BUS_DATA),
    .bus_valid (BUS_VALID),    .bus_ctrl  (ctl_in[1]),
    .chain_in  (1'b0),         .range_in  (1'b0),
    .chain_out (chain1),       .range_out (range1),
    .hit       (hit[1])
  );
  wcu_unit u_unit0 (
    .clk       (CLK),          .nrst      (NRST),
    .tap_rst_n (trst_n_s),     .addr_val  (av[0]),
    .addr_msk  (am[0]),        .data_val  (dv[0]),
    .data_msk  (dm[0]),        .ctrl_val  (cv[0]),
    .ctrl_msk  (cm[0]),        .ctrl_wr   (cwr[0]),
    .bus_addr  (BUS_ADDR),     .bus_data  (BUS_DATA),
    .bus_valid (BUS_VALID),    .bus_ctrl  (ctl_in[0]),
    .chain_in  (chain1),       .range_in  (range1),
    .chain_out (),             .range_out (),
    .hit       (hit[0])
  );
  assign LINK_OUTPUT  = chain1;
  assign RANGE_OUTPUT = range1;

  // ---------------------------------------------------------------------------
  // Break request and priorities
  // ---------------------------------------------------------------------------
  logic brk;
  // A fetch that aborts does not break; a data abort still breaks.
  assign brk = |hit && !(PREFETCH_ABORT && !FETCH_OR_DATA_BIT);
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      DEBUG_BREAK_REQUEST <= 1'b0;
      INTERRUPTS_DISABLED <= 1'b0;
      IRQ_REMEMBERED      <= 1'b0;
      ABORT_REMEMBERED    <= 1'b0;
    end else begin
      DEBUG_BREAK_REQUEST <= brk;
      if (brk) begin
        INTERRUPTS_DISABLED <= 1'b1;
        IRQ_REMEMBERED      <= IRQ_REMEMBERED | IRQ_PENDING;
        ABORT_REMEMBERED    <= ABORT_REMEMBERED |
                               (DATA_ABORT && FETCH_OR_DATA_BIT);
      end else if (!trst_n_s) begin
        INTERRUPTS_DISABLED <= 1'b0;
        IRQ_REMEMBERED      <= 1'b0;
        ABORT_REMEMBERED    <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  break_follows_a: assert property (@(posedge CLK) disable iff (!NRST)
    brk |=> DEBUG_BREAK_REQUEST) else $error("break request missed");
  prefetch_wins_a: assert property (@(posedge CLK) disable iff (!NRST)
    (PREFETCH_ABORT && !FETCH_OR_DATA_BIT) |=> !DEBUG_BREAK_REQUEST)
    else $error("prefetch abort did not win");
  enable_gate_a: assert property (@(posedge CLK) disable iff (!NRST)
    (!cv[0][8] && !cv[1][8]) |=> !DEBUG_BREAK_REQUEST)
    else $error("break without enable");
  upd_only_a: assert property (@(posedge CLK) disable iff (!NRST)
    $changed(cv[0]) |-> $past(upd_pulse)) else $error("write outside update");
  irq_keep_a: assert property (@(posedge CLK) disable iff (!NRST)
    (brk && IRQ_PENDING) |=> (IRQ_REMEMBERED && INTERRUPTS_DISABLED))
    else $error("interrupt not remembered");
  abort_keep_a: assert property (@(posedge CLK) disable iff (!NRST)
    (brk && DATA_ABORT && FETCH_OR_DATA_BIT) |=> ABORT_REMEMBERED)
    else $error("abort not remembered");
  range_link_a: assert property (@(posedge CLK) disable iff (!NRST)
    (hit[0] && cv[0][wcu_pkg::CTL_RANGE] && !cm[0][wcu_pkg::CTL_RANGE])
    |-> RANGE_OUTPUT) else $error("range output mismatch");
  mask_all_a: assert property (@(posedge CLK) disable iff (!NRST)
    (BUS_VALID && cv[1][8] && am[1] == 32'hFFFF_FFFF &&
     dm[1] == 32'hFFFF_FFFF && cm[1] == 8'hFF && !PREFETCH_ABORT)
    |=> DEBUG_BREAK_REQUEST) else $error("full mask did not match");
  cov_write_c: cover property (@(posedge CLK) upd_pulse && sc_wr);
  cov_read_c:  cover property (@(posedge CLK) upd_pulse && !sc_wr);
  cov_break_c: cover property (@(posedge CLK) DEBUG_BREAK_REQUEST);
  cov_chain_c: cover property (@(posedge CLK) chain1 && hit[0]);
endmodule : wcu_top

// file: dv/wcu_dbg_model.sv
// Debugger model that drives whole scan frames on the test pins.
`timescale 1ns/100ps
module wcu_dbg_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  localparam int HALF = 40;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // --------------------
  // Test clock cycles
  // --------------------
  // The bit out is taken late in the high phase: the design moved it out on
  // the previous falling edge, and only the next falling edge replaces it.
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #HALF;
    tck = 1'b1;
    #(HALF - 5);
    o = tdo;
    #5;
    tck = 1'b0;
  endtask : tick

  // Final branch offset, in words, back to the interrupted program.
  function automatic int ret_branch(input logic exc, input int n,
                                    input int s);
    return -((exc ? 3 : 4) + n + 3 * s);
  endfunction : ret_branch

  task automatic tap_reset();
    logic o;
    repeat (5) tick(1'b1, ~tdi, o);
    tick(1'b0, ~tdi, o);
  endtask : tap_reset

  // From idle: select, capture, shift the whole word, update, back to idle.
  // The clock then stands still and the data pin is toggled once more.
  task automatic scan(input logic [37:0] w, output logic [37:0] r);
    logic o;
    tick(1'b1, ~tdi, o);
    tick(1'b0, ~tdi, o);
    tick(1'b0, ~tdi, o);
    for (int i = 0; i < wcu_pkg::SCAN_LEN; i++) begin
      tick(i == wcu_pkg::SCAN_LEN - 1, w[i], o);
      r[i] = o;
    end
    tick(1'b1, ~tdi, o);
    tick(1'b0, ~tdi, o);
    tdi = ~tdi;
  endtask : scan
endmodule : wcu_dbg_model

// file: dv/testbench.sv
// Self-checking bench for the two-unit watch comparator.
`timescale 1ns/100ps
module testbench;
  // Bus byte of a row: write, size[1:0], fetch, user, ext[1:0], pabt.
  typedef struct packed {
    logic [8:0]  cv;
    logic [7:0]  cm;
    logic [15:0] a;
    logic [7:0]  bus;
    logic        brk;
  } wcu_row_t;
  logic        clk;
  logic        nrst;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tap_rst_n;
  logic        sel;
  logic [31:0] bus_addr;
  logic [31:0] bus_data;
  logic        bus_valid;
  logic        bus_write;
  logic [1:0]  bus_size;
  logic        fetch;
  logic        user;
  logic [1:0]  ext;
  logic        pabt;
  logic        dabt;
  logic        irq;
  logic        brk;
  logic        link;
  logic        rng;
  logic        idis;
  logic        irq_mem;
  logic        abt_mem;
  logic        b_seen;
  logic        r_seen;
  logic [31:0] d;
  wcu_row_t    h;
  int          fail_count;
  int          comparisons;
  int          cycles;
  wcu_row_t    rows [16] = '{
    '{9'h100, 8'hFF, 16'h1000, 8'h00, 1'b1},
    '{9'h000, 8'hFF, 16'h1000, 8'h00, 1'b0},
    '{9'h100, 8'hFF, 16'h100A, 8'h00, 1'b1},
    '{9'h100, 8'hFF, 16'h1010, 8'h00, 1'b0},
    '{9'h101, 8'hFE, 16'h1000, 8'h80, 1'b1},
    '{9'h101, 8'hFE, 16'h1000, 8'h00, 1'b0},
    '{9'h104, 8'hF9, 16'h1000, 8'h40, 1'b1},
    '{9'h104, 8'hF9, 16'h1000, 8'h20, 1'b0},
    '{9'h108, 8'hF7, 16'h1000, 8'h10, 1'b1},
    '{9'h108, 8'hF7, 16'h1000, 8'h00, 1'b0},
    '{9'h110, 8'hEF, 16'h1000, 8'h08, 1'b1},
    '{9'h110, 8'hEF, 16'h1000, 8'h00, 1'b0},
    '{9'h120, 8'hDF, 16'h1000, 8'h02, 1'b1},
    '{9'h120, 8'hDF, 16'h1000, 8'h04, 1'b0},
    '{9'h100, 8'hFF, 16'h1000, 8'h01, 1'b0},
    '{9'h100, 8'hFF, 16'h1000, 8'h11, 1'b1}};

  wcu_top u_dut (
    .CLK(clk), .NRST(nrst), .TCK(tck), .TMS(tms), .TDI(tdi),
    .DEBUG_TAP_RESET_N(tap_rst_n), .SCAN_SELECT(sel), .TDO(tdo),
    .BUS_ADDR(bus_addr), .BUS_DATA(bus_data), .BUS_VALID(bus_valid),
    .BUS_WRITE(bus_write), .BUS_SIZE(bus_size),
    .FETCH_OR_DATA_BIT(fetch), .USER_OR_PRIVILEGED_BIT(user),
    .EXTERNAL_CONDITION_INPUT(ext), .PREFETCH_ABORT(pabt),
    .DATA_ABORT(dabt), .IRQ_PENDING(irq), .DEBUG_BREAK_REQUEST(brk),
    .LINK_OUTPUT(link), .RANGE_OUTPUT(rng), .INTERRUPTS_DISABLED(idis),
    .IRQ_REMEMBERED(irq_mem), .ABORT_REMEMBERED(abt_mem));
  wcu_dbg_model u_dbg (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  // --------------------
  // Helpers
  // --------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic edge1();
    @(posedge clk);
    #1;
  endtask : edge1

  function automatic logic [4:0] ra(input logic u, input logic [2:0] s);
    return (u ? wcu_pkg::REG_U1_BASE : wcu_pkg::REG_U0_BASE) + {2'h0, s};
  endfunction : ra

  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    logic [37:0] r;
    u_dbg.scan({1'b1, a, v}, r);
  endtask : wr

  // A read needs a second frame to bring the word out.
  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    logic [37:0] r;
    u_dbg.scan({1'b0, a, 32'hFFFF_FFFF}, r);
    u_dbg.scan({1'b0, a, 32'h0000_0000}, r);
    v = r[31:0];
  endtask : rd

  task automatic cyc(input wcu_row_t r, input logic [31:0] dv);
    edge1();
    bus_addr = {16'h0000, r.a};
    bus_data = dv;
    {bus_write, bus_size, fetch, user, ext, pabt} = r.bus;
    bus_valid = 1'b1;
    #8;
    r_seen = rng;
    edge1();
    bus_valid = 1'b0;
    b_seen = brk;
  endtask : cyc

  task automatic tap_pulse();
    edge1();
    tap_rst_n = 1'b0;
    repeat (4) edge1();
    tap_rst_n = 1'b1;
  endtask : tap_pulse

  // --------------------
  // Main sequence
  // --------------------
  initial begin
    {nrst, bus_addr, bus_data, bus_valid, bus_write, bus_size} = '0;
    {fetch, user, ext, pabt, dabt, irq} = '0;
    tap_rst_n = 1'b1;
    sel = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (4) edge1();
    u_dbg.tap_reset();
    rd(ra(0, 3'h5), d);
    chk("ctrl mask reset", d, 32'h0000_00FF);
    rd(ra(0, 3'h4), d);
    chk("ctrl value reset", d, 32'h0000_0000);
    wr(ra(0, 3'h0), 32'h0000_1000);
    wr(ra(0, 3'h1), 32'h0000_000F);
    wr(ra(0, 3'h3), 32'hFFFF_FFFF);
    edge1();
    sel = 1'b0;
    wr(ra(0, 3'h0), 32'h0000_2000);
    edge1();
    sel = 1'b1;
    rd(ra(0, 3'h0), d);
    chk("addr value", d, 32'h0000_1000);
    wr(5'h1F, 32'hA5A5_A5A5);
    rd(5'h1F, d);
    chk("unmapped read", d, 32'h0000_0000);
    foreach (rows[i]) begin
      wr(ra(0, 3'h4), {23'h0, rows[i].cv});
      wr(ra(0, 3'h5), {24'h0, rows[i].cm});
      cyc(rows[i], 32'h0000_0000);
      chk("break row", b_seen, rows[i].brk);
    end
    tap_pulse();
    chk("irq disable cleared", idis, 1'b0);
    u_dbg.tap_reset();
    h = rows[0];
    h.bus = 8'h10;
    edge1();
    dabt = 1'b1;
    irq = 1'b1;
    cyc(h, 32'h0000_0000);
    dabt = 1'b0;
    irq = 1'b0;
    repeat (3) edge1();
    chk("watch over abort", b_seen, 1'b1);
    chk("abort kept", abt_mem, 1'b1);
    chk("irq kept", irq_mem, 1'b1);
    chk("irq disabled", idis, 1'b1);
    wr(ra(1, 3'h0), 32'h0000_2000);
    wr(ra(1, 3'h2), 32'h0000_0055);
    h.a = 16'h2000;
    cyc(h, 32'h0000_0055);
    chk("range out", r_seen, 1'b1);
    chk("link set", link, 1'b1);
    wr(ra(0, 3'h4), 32'h0000_0140);
    wr(ra(0, 3'h5), 32'h0000_00BF);
    cyc(rows[0], 32'h0000_0000);
    chk("chained break", b_seen, 1'b1);
    chk("link held", link, 1'b1);
    cyc(h, 32'h0000_0000);
    chk("range miss", r_seen, 1'b0);
    chk("link loads miss", link, 1'b0);
    cyc(rows[0], 32'h0000_0000);
    chk("chain blocks break", b_seen, 1'b0);
    cyc(h, 32'h0000_0055);
    chk("link set again", link, 1'b1);
    wr(ra(1, 3'h4), 32'h0000_0100);
    chk("link clear on write", link, 1'b0);
    wr(ra(1, 3'h1), 32'hFFFF_FFFF);
    wr(ra(1, 3'h3), 32'hFFFF_FFFF);
    wr(ra(0, 3'h4), 32'h0000_0180);
    wr(ra(0, 3'h5), 32'h0000_007F);
    cyc(rows[0], 32'h0000_0000);
    chk("unit1 break", b_seen, 1'b1);
    chk("link on unit1", link, 1'b1);
    tap_pulse();
    chk("link clear on tap reset", link, 1'b0);
    d = u_dbg.ret_branch(1'b0, 3, 0);
    chk("return after break", d, 32'hFFFF_FFF9);
    d = u_dbg.ret_branch(1'b1, 3, 1);
    chk("return after exception", d, 32'hFFFF_FFF7);
    print_verdict();
  end
endmodule : testbench
